// ### shared/gpa_pkg.sv
// package: register map, reset values and bus carrier for the six-pin port
package gpa_pkg;
	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int unsigned PIN_W  = 6;          // pins 5..0
	localparam int unsigned ADDR_W = 8;          // byte address
	localparam int unsigned DATA_W = 32;         // bus data
	localparam int unsigned REG_W  = 8;          // register width

	// ---------------------------------------------------------------
	// register byte addresses, one aligned word each
	// ---------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_DIR  = 8'h00;  // pin_direction
	localparam logic [ADDR_W-1:0] OFS_LAT  = 8'h04;  // output_latch
	localparam logic [ADDR_W-1:0] OFS_ANS  = 8'h08;  // analog_select
	localparam logic [ADDR_W-1:0] OFS_WPU  = 8'h0C;  // pullup_enable
	localparam logic [ADDR_W-1:0] OFS_LVL  = 8'h10;  // input_threshold_select
	localparam logic [ADDR_W-1:0] OFS_PORT = 8'h14;  // port_pin_data
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h18;  // global_pullup_disable, bit 0

	// ---------------------------------------------------------------
	// implemented-bit masks
	// ---------------------------------------------------------------
	localparam logic [PIN_W-1:0] MASK_DIR  = 6'h37;  // bit 3 fixed at one
	localparam logic [PIN_W-1:0] MASK_LAT  = 6'h37;  // bit 3 has no latch
	localparam logic [PIN_W-1:0] MASK_ANS  = 6'h17;  // pins 4, 2, 1, 0
	localparam logic [PIN_W-1:0] MASK_ALL  = 6'h3F;  // pins 5..0
	localparam logic [PIN_W-1:0] FIXED_DIR = 6'h08;  // input-only pin
	localparam int unsigned      GPD_BIT   = 0;      // control bit position

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [PIN_W-1:0] RST_DIR = 6'h3F;
	localparam logic [PIN_W-1:0] RST_LAT = 6'h00;
	localparam logic [PIN_W-1:0] RST_ANS = 6'h17;
	localparam logic [PIN_W-1:0] RST_WPU = 6'h3F;
	localparam logic [PIN_W-1:0] RST_LVL = 6'h04;
	localparam logic             RST_GPD = 1'b1;
	localparam logic [PIN_W-1:0] ZERO_PINS = 6'h00;
	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

	// ---------------------------------------------------------------
	// bus carrier and response state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic              read;       // avalon read
		logic              write;      // avalon write
		logic [ADDR_W-1:0] address;    // byte address
		logic [DATA_W-1:0] writedata;  // write data
	} gpa_bus_req_s;

	typedef enum logic [0:0] {
		GPA_IDLE = 1'b0,               // waiting for a request
		GPA_RESP = 1'b1                // read data valid this cycle
	} gpa_bus_state_e;
endpackage

// ### src/gpa_port.sv
// six-pin general purpose port: registers, pin drivers, input select
//
// Functional notes
// R1: direction one tri-states pin; zero drives it
// R2: input-only pin direction reads one, ignores writes
// R3: port write hits latch; read returns pins
// R4: latch holds pins 5,4,2,1,0 only
// R5: unimplemented register bits read as zero
// R6: analog select zero keeps pin digital
// R7: analog select one disables digital input buffer
// R8: software sets direction input for analog pins
// R9: pull-up enable bit switches pin pull-up
// R10: global pull-up disable forces all pull-ups off
// R11: pull-up off while pin is an output
// R12: threshold bit picks Schmitt or TTL input
// R13: analog pin reads as zero digitally
// R14: analog select never blocks digital output
// R15: pull-up is enable, not disable, and input
`timescale 1ns/1ps
module gpa_port (
	// clock and reset
	input  wire logic                         sys_clk_in,
	input  wire logic                         nrst_in,
	// avalon-mm slave
	input  wire gpa_pkg::gpa_bus_req_s        avs_req_in,
	output logic [gpa_pkg::DATA_W-1:0]        avs_readdata_out,
	output logic                              avs_waitrequest_out,
	// pin side: two input buffers per pin, driver and pull-up
	input  wire logic [gpa_pkg::PIN_W-1:0]    pin_ttl_in,
	input  wire logic [gpa_pkg::PIN_W-1:0]    pin_st_in,
	output logic [gpa_pkg::PIN_W-1:0]         pin_data_out,
	output logic [gpa_pkg::PIN_W-1:0]         pin_oe_n_out,
	output logic [gpa_pkg::PIN_W-1:0]         pin_pullup_out,
	output logic [gpa_pkg::PIN_W-1:0]         analog_select_out,
	// digital input levels for peripherals and change detection
	output logic [gpa_pkg::PIN_W-1:0]         digital_in_out
);
	import gpa_pkg::*;

	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	logic [PIN_W-1:0] dir;          // pin_direction, one = input
	logic [PIN_W-1:0] lat;          // output_latch
	logic [PIN_W-1:0] ans;          // analog_select
	logic [PIN_W-1:0] wpu;          // pullup_enable
	logic [PIN_W-1:0] lvl;          // input_threshold_select
	logic             gpd;          // global_pullup_disable
	logic [PIN_W-1:0] next_dir;
	logic [PIN_W-1:0] next_lat;
	logic [PIN_W-1:0] next_ans;
	logic [PIN_W-1:0] next_wpu;
	logic [PIN_W-1:0] next_lvl;
	logic             next_gpd;

	// bus response state
	gpa_bus_state_e    bus_state;
	gpa_bus_state_e    next_bus_state;
	logic [DATA_W-1:0] next_readdata;
	logic              wr_take;      // write accepted this edge
	logic [PIN_W-1:0]  wr_pins;      // low six bits of write data

	// pin synchronisers and selected levels
	logic [PIN_W-1:0] ttl_meta;     // first stage, read only by ttl_sync
	logic [PIN_W-1:0] ttl_sync;
	logic [PIN_W-1:0] st_meta;      // first stage, read only by st_sync
	logic [PIN_W-1:0] st_sync;
	logic [PIN_W-1:0] sel_level;    // threshold-selected level
	logic [PIN_W-1:0] next_digital;
	logic [PIN_W-1:0] next_pullup;

	// ---------------------------------------------------------------
	// bus handshake
	// ---------------------------------------------------------------
	// writes complete at once; reads take one extra cycle so that
	// read data always comes straight from a flop
	assign avs_waitrequest_out = avs_req_in.read && (bus_state == GPA_IDLE);
	assign wr_take = avs_req_in.write && !avs_req_in.read;
	assign wr_pins = avs_req_in.writedata[PIN_W-1:0];

	// next register values from accepted writes
	always_comb begin
		next_dir = dir;
		next_lat = lat;
		next_ans = ans;
		next_wpu = wpu;
		next_lvl = lvl;
		next_gpd = gpd;
		if (wr_take) begin
			unique case (avs_req_in.address)
				// input-only pin stays input whatever is written
				OFS_DIR: begin
					next_dir = (wr_pins & MASK_DIR) | FIXED_DIR;  // [R1] [R2]
				end
				// port data writes land in the latch, same as latch writes
				OFS_LAT, OFS_PORT: begin
					next_lat = wr_pins & MASK_LAT;  // [R3] [R4]
				end
				OFS_ANS: begin
					next_ans = wr_pins & MASK_ANS;  // [R6] [R7]
				end
				OFS_WPU: begin
					next_wpu = wr_pins & MASK_ALL;  // [R9]
				end
				OFS_LVL: begin
					next_lvl = wr_pins & MASK_ALL;  // [R12]
				end
				OFS_CTRL: begin
					next_gpd = avs_req_in.writedata[GPD_BIT];  // [R10]
				end
				// unmapped: write is accepted and dropped
				default: begin
				end
			endcase
		end
	end

	// register flops
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			dir <= RST_DIR;
			lat <= RST_LAT;
			ans <= RST_ANS;
			wpu <= RST_WPU;
			lvl <= RST_LVL;
			gpd <= RST_GPD;
		end else begin
			dir <= next_dir;
			lat <= next_lat;
			ans <= next_ans;
			wpu <= next_wpu;
			lvl <= next_lvl;
			gpd <= next_gpd;
		end
	end

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	// data is captured when the read arrives; upper bits pad with zero
	always_comb begin
		next_bus_state = GPA_IDLE;
		next_readdata  = avs_readdata_out;
		if (avs_req_in.read && bus_state == GPA_IDLE) begin
			next_bus_state = GPA_RESP;
			next_readdata  = ZERO_WORD;  // [R5]
			unique case (avs_req_in.address)
				OFS_DIR:  next_readdata[PIN_W-1:0] = dir;
				OFS_LAT:  next_readdata[PIN_W-1:0] = lat;
				OFS_ANS:  next_readdata[PIN_W-1:0] = ans;
				OFS_WPU:  next_readdata[PIN_W-1:0] = wpu;
				OFS_LVL:  next_readdata[PIN_W-1:0] = lvl;
				// live pin levels, analog pins already forced low
				OFS_PORT: next_readdata[PIN_W-1:0] = digital_in_out;  // [R3] [R13]
				OFS_CTRL: next_readdata[GPD_BIT] = gpd;
				// unmapped address reads zero
				default:  next_readdata = ZERO_WORD;
			endcase
		end
	end

	// bus response flops
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			bus_state        <= GPA_IDLE;
			avs_readdata_out <= ZERO_WORD;
		end else begin
			bus_state        <= next_bus_state;
			avs_readdata_out <= next_readdata;
		end
	end

	// ---------------------------------------------------------------
	// pin input path
	// ---------------------------------------------------------------
	// both buffers are asynchronous to the core clock
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ttl_meta <= ZERO_PINS;
			ttl_sync <= ZERO_PINS;
			st_meta  <= ZERO_PINS;
			st_sync  <= ZERO_PINS;
		end else begin
			ttl_meta <= pin_ttl_in;
			ttl_sync <= ttl_meta;
			st_meta  <= pin_st_in;
			st_sync  <= st_meta;
		end
	end

	// per-pin threshold choice; switching it while a peripheral
	// listens can show a false edge, software must avoid that
	for (genvar i = 0; i < PIN_W; i++) begin : g_thresh
		assign sel_level[i] = lvl[i] ? st_sync[i] : ttl_sync[i];  // [R12]
	end

	// digital level and effective pull-up
	always_comb begin
		// analog pins have the digital buffer off and read zero
		next_digital = sel_level & ~ans;  // [R7] [R13] [R6]
		// pull-up only on inputs, only while not globally disabled
		next_pullup  = wpu & dir & {PIN_W{!gpd}};  // [R9] [R10] [R11] [R15]
	end

	// output flops; driver and latch follow registers directly
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			digital_in_out <= ZERO_PINS;
			pin_pullup_out <= ZERO_PINS;
		end else begin
			digital_in_out <= next_digital;
			pin_pullup_out <= next_pullup;
		end
	end

	// driver ignores analog select entirely
	assign pin_data_out      = lat;  // [R14]
	assign pin_oe_n_out      = dir;  // [R1] [R14]
	assign analog_select_out = ans;  // [R7]

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);

	// direction write reaches the driver enables next cycle
	property p_dir_write;
		wr_take && avs_req_in.address == OFS_DIR
		|=> pin_oe_n_out == (($past(wr_pins) & MASK_DIR) | FIXED_DIR);
	endproperty
	a_dir_write: assert property (p_dir_write) else $error("direction write lost");  // [R1]

	// input-only pin never driven
	property p_fixed_input;
		(pin_oe_n_out & FIXED_DIR) == FIXED_DIR && (pin_data_out & FIXED_DIR) == ZERO_PINS;
	endproperty
	a_fixed_input: assert property (p_fixed_input) else $error("input-only pin driven");  // [R2] [R4]

	// port data write updates the latch
	property p_port_write;
		wr_take && avs_req_in.address == OFS_PORT
		|=> pin_data_out == ($past(wr_pins) & MASK_LAT);
	endproperty
	a_port_write: assert property (p_port_write) else $error("port write missed latch");  // [R3]

	// port read returns the pin levels held when it was taken
	property p_port_read;
		avs_req_in.read && bus_state == GPA_IDLE && avs_req_in.address == OFS_PORT
		|=> !avs_waitrequest_out && avs_readdata_out == {26'h000_0000, $past(digital_in_out)};
	endproperty
	a_port_read: assert property (p_port_read) else $error("port read wrong");  // [R3]

	// answered reads never carry bits above the register
	property p_upper_zero;
		bus_state == GPA_RESP |-> avs_readdata_out[DATA_W-1:PIN_W] == 26'h000_0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("unimplemented bits set");  // [R5]

	// analog select holds pins 4,2,1,0 only
	property p_ans_mask;
		(analog_select_out & ~MASK_ANS) == ZERO_PINS;
	endproperty
	a_ans_mask: assert property (p_ans_mask) else $error("analog bit on missing pin");  // [R5] [R7]

	// analog pins read zero, digital pins follow threshold choice
	property p_digital_level;
		##1 digital_in_out == ($past(sel_level) & ~$past(ans));
	endproperty
	a_digital_level: assert property (p_digital_level) else $error("digital level wrong");  // [R12] [R13]

	// global disable kills every pull-up
	property p_global_off;
		gpd |=> pin_pullup_out == ZERO_PINS;
	endproperty
	a_global_off: assert property (p_global_off) else $error("pull-up on while disabled");  // [R10]

	// outputs never carry a pull-up
	property p_output_no_pullup;
		##1 (pin_pullup_out & ~$past(pin_oe_n_out)) == ZERO_PINS;
	endproperty
	a_output_no_pullup: assert property (p_output_no_pullup) else $error("pull-up on output");  // [R11]

	// effective pull-up equation with one-cycle reach
	property p_pullup_eq;
		##1 pin_pullup_out == ($past(wpu) & $past(dir) & {PIN_W{!$past(gpd)}});
	endproperty
	a_pullup_eq: assert property (p_pullup_eq) else $error("pull-up mismatch");  // [R9] [R15]

	// an accepted read waits exactly one cycle, then waitrequest drops
	property p_read_wait;
		avs_req_in.read && bus_state == GPA_IDLE |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read latency wrong");

	// scenarios worth seeing
	c_port_read:  cover property (avs_req_in.read && avs_req_in.address == OFS_PORT ##1 bus_state == GPA_RESP);
	c_analog_out: cover property (|(analog_select_out & ~pin_oe_n_out));
	c_pullup_on:  cover property (|pin_pullup_out);
	c_st_select:  cover property (|(lvl & ~ans & (st_sync ^ ttl_sync)));
endmodule

// ### dv/gpa_pin_model.sv
// partner model: external circuitry on the six port pins
`timescale 1ns/1ps
module gpa_pin_model (
	// clock for the floating-line pattern
	input  wire logic [0:0]                sys_clk_in,
	// device side of each pin
	input  wire logic [gpa_pkg::PIN_W-1:0] pin_data_in,
	input  wire logic [gpa_pkg::PIN_W-1:0] pin_oe_n_in,
	input  wire logic [gpa_pkg::PIN_W-1:0] pin_pullup_in,
	// external sources set by the bench
	input  wire logic [gpa_pkg::PIN_W-1:0] ext_en_in,
	input  wire logic [gpa_pkg::PIN_W-1:0] ext_ttl_in,
	input  wire logic [gpa_pkg::PIN_W-1:0] ext_st_in,
	// buffer outputs back into the device
	output logic [gpa_pkg::PIN_W-1:0]      pin_ttl_out,
	output logic [gpa_pkg::PIN_W-1:0]      pin_st_out
);
	import gpa_pkg::*;
	logic [PIN_W-1:0] drift = 6'h15;  // an undriven line never keeps a stale level
	// floating lines change every cycle
	always @(posedge sys_clk_in) begin
		drift <= ~drift;
	end
	// resolve each wire: device driver, external source, pull-up, else floating
	always_comb begin
		for (int i = 0; i < PIN_W; i++) begin
			if (!pin_oe_n_in[i]) begin  // device drives its latch
				pin_ttl_out[i] = pin_data_in[i];
				pin_st_out[i]  = pin_data_in[i];
			end else if (ext_en_in[i]) begin  // thresholds may see different levels
				pin_ttl_out[i] = ext_ttl_in[i];
				pin_st_out[i]  = ext_st_in[i];
			end else begin  // weak pull-up or a wandering line
				pin_ttl_out[i] = pin_pullup_in[i] | drift[i];
				pin_st_out[i]  = pin_pullup_in[i] | drift[i];
			end
		end
	end
endmodule

// ### dv/gpa_port_tb.sv
// self-checking bench for the six-pin port
`timescale 1ns/1ps
module gpa_port_tb;
	import gpa_pkg::*;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic              sys_clk_in = 1'b0;
	logic              nrst_in    = 1'b0;
	gpa_bus_req_s      req        = '0;
	logic [DATA_W-1:0] rdata;
	logic              wait_req;
	logic [PIN_W-1:0]  ttl, st, pdata, oe_n, pull, ansel, din;
	// external sources hold every pin high from the start, so no line floats before it is tested
	logic [PIN_W-1:0]  ext_en = 6'h3F, ext_ttl = 6'h3F, ext_st = 6'h3F;
	int                error_cnt = 0;
	int                n_tests   = 0;

	always #10 sys_clk_in = ~sys_clk_in;  // 50 MHz

	gpa_port gpa_port_i (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .avs_req_in(req),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .pin_ttl_in(ttl),
		.pin_st_in(st), .pin_data_out(pdata), .pin_oe_n_out(oe_n), .pin_pullup_out(pull),
		.analog_select_out(ansel), .digital_in_out(din));
	gpa_pin_model gpa_pin_model_i (.sys_clk_in(sys_clk_in), .pin_data_in(pdata),
		.pin_oe_n_in(oe_n), .pin_pullup_in(pull), .ext_en_in(ext_en), .ext_ttl_in(ext_ttl),
		.ext_st_in(ext_st), .pin_ttl_out(ttl), .pin_st_out(st));

	// ---------------------------------------------------------------
	// report and compare
	// ---------------------------------------------------------------
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check_word(input logic [DATA_W-1:0] got, exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic check_pins(input logic [PIN_W-1:0] got, exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// ---------------------------------------------------------------
	// bus master: request held until the edge that sees waitrequest low
	// ---------------------------------------------------------------
	task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] r);
		int n;
		n = 0;
		r = ZERO_WORD;
		@(posedge sys_clk_in);
		req <= '{read: rd, write: !rd, address: a, writedata: wd};
		do begin  // waitrequest sampled at the rising edge, as the slave sees it
			@(posedge sys_clk_in);
			n++;
		end while (wait_req !== 1'b0 && n < 20);
		if (wait_req !== 1'b0) begin  // a slave that never answers ends the run
			error_cnt++;
			$display("wrong value at %0t: bus hang", $time);
			finish_test();
		end
		r = rdata;  // read data stands at the edge that ends the wait
		req <= '0;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] dummy;
		xfer(1'b0, a, d, dummy);
	endtask
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		logic [DATA_W-1:0] r;
		xfer(1'b1, a, ZERO_WORD, r);
		check_word(r, e, "register read");
	endtask
	// input path is two sync flops plus an output flop
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		rd_chk(OFS_DIR, 32'h0000_003F);
		rd_chk(OFS_LAT, 32'h0000_0000);
		rd_chk(OFS_ANS, 32'h0000_0017);
		rd_chk(OFS_WPU, 32'h0000_003F);
		rd_chk(OFS_LVL, 32'h0000_0004);
		rd_chk(OFS_CTRL, 32'h0000_0001);
		rd_chk(8'h1C, 32'h0000_0000);
		settle(0);
		check_pins(oe_n, 6'h3F, "drivers off");
		check_pins(pull, 6'h00, "pull-ups off");
		check_pins(ansel, 6'h17, "analog pins");
		check_pins(din, 6'h28, "analog reads low");
	endtask
	task automatic t_masks;
		wr(OFS_DIR, 32'h0000_0000);
		rd_chk(OFS_DIR, 32'h0000_0008);
		wr(OFS_LAT, 32'hFFFF_FFFF);
		rd_chk(OFS_LAT, 32'h0000_0037);
		wr(OFS_ANS, 32'hFFFF_FFFF);
		rd_chk(OFS_ANS, 32'h0000_0017);
		wr(OFS_LVL, 32'hFFFF_FFFF);
		rd_chk(OFS_LVL, 32'h0000_003F);
		settle(1);
		check_pins(oe_n, 6'h08, "drivers on");
		check_pins(pdata, 6'h37, "latch on pins with analog set");
		wr(OFS_PORT, 32'h0000_002A);
		rd_chk(OFS_LAT, 32'h0000_0022);
	endtask
	task automatic t_inputs;
		wr(OFS_DIR, 32'h0000_003F);  // analog pins stay inputs
		wr(OFS_ANS, 32'h0000_0000);
		wr(OFS_LAT, 32'h0000_0015);
		wr(OFS_LVL, 32'h0000_0000);
		ext_en  <= 6'h3F;
		ext_ttl <= 6'h2A;
		ext_st  <= 6'h15;
		settle(5);
		rd_chk(OFS_PORT, 32'h0000_002A);
		check_pins(din, 6'h2A, "ttl input");
		wr(OFS_LVL, 32'h0000_003F);
		settle(5);
		rd_chk(OFS_PORT, 32'h0000_0015);
		wr(OFS_LVL, 32'h0000_000F);
		settle(5);
		rd_chk(OFS_PORT, 32'h0000_0025);
		wr(OFS_ANS, 32'h0000_0017);
		settle(5);
		rd_chk(OFS_PORT, 32'h0000_0020);
		check_pins(din, 6'h20, "buffer off");
		wr(OFS_ANS, 32'h0000_0010);
		settle(5);
		rd_chk(OFS_PORT, 32'h0000_0025);
	endtask
	task automatic t_pullup;
		ext_en <= 6'h00;
		wr(OFS_CTRL, 32'h0000_0000);
		settle(1);
		check_pins(pull, 6'h3F, "pull-ups on");
		settle(4);
		rd_chk(OFS_PORT, 32'h0000_002F);
		wr(OFS_DIR, 32'h0000_0030);
		settle(1);
		check_pins(pull, 6'h38, "outputs lose pull-up");
		wr(OFS_WPU, 32'h0000_0029);
		settle(1);
		check_pins(pull, 6'h28, "enable and input");
		wr(OFS_CTRL, 32'h0000_0001);
		settle(1);
		check_pins(pull, 6'h00, "global disable");
	endtask

	// main sequence: reset for five cycles, then each scenario
	initial begin
		repeat (5) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		t_reset();
		t_masks();
		t_inputs();
		t_pullup();
		finish_test();
	end
endmodule
